// [dv/tsw_mem_engine.sv]
// Model of the four memory self-test engines.
// Assumes launch pulses in sys_clk domain; answers after DELAY cycles.
module tsw_mem_engine #(
  parameter int DELAY = 20,
  parameter logic [3:0] PASS_MASK = 4'b1110
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Engine side
  input wire logic [3:0] memTestGo,
  output logic [3:0] memTestFinished,
  output logic [3:0] memTestPassed
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [4];
  // Result is only trustworthy with finished; with no engine finished show the inverse
  assign memTestPassed = memTestFinished ? PASS_MASK : ~PASS_MASK;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '{default: 0};
      memTestFinished <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        memTestFinished[i] <= cnt[i] == 1;
        if (memTestGo[i])
          cnt[i] <= DELAY;
        else if (cnt[i] != 0)
          cnt[i] <= cnt[i] - 1;
      end
    end
  end
endmodule // tsw_mem_engine

// [dv/tsw_regs_asserts.sv]
// Port-level checker for the switch test and rate registers.
// Assumes binding into tsw_regs; one clock, async active-low reset.
`include "tsw_regs_map.svh"
module tsw_regs_asserts #(
  parameter logic [3:0] REVISION_NUMBER = 4'h1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Host port
  input wire logic hostRead,
  input wire logic [13:0] hostAddr,
  input wire logic [15:0] hostRdData,
  input wire logic hostRdValid,
  // Mode and settings
  input wire logic bp32Mode,
  input wire logic [63:0] bpInRates,
  input wire logic [63:0] bpOutRates,
  input wire logic [31:0] bpStreamActive,
  input wire logic bpAdvanceHalfStep,
  input wire logic [3:0] memTestGo,
  input wire logic selftestEnable,
  input wire tsw_pkg::tsw_window_s localSendWin,
  input wire tsw_pkg::tsw_window_s localRecvWin,
  input wire logic [8:0] localTxExtra,
  input wire logic [8:0] localRxExtra
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Three cycles of mode covers the one-cycle lag
  property p_bp32_active;
    bp32Mode [*3] |-> bpStreamActive == 32'h0000_FFFF;
  endproperty
  a_bp32_active: assert property (p_bp32_active) else $error("bp32 streams");
  property p_normal_active;
    !bp32Mode [*3] |-> bpStreamActive == 32'hFFFF_FFFF && !bpAdvanceHalfStep;
  endproperty
  a_normal_active: assert property (p_normal_active) else $error("normal mode");
  property p_half_step;
    bp32Mode [*3] |-> bpAdvanceHalfStep;
  endproperty
  a_half_step: assert property (p_half_step) else $error("advance scale");
  property p_bp32_rates;
    bp32Mode [*3] |-> (bpInRates | bpOutRates) == 64'h0;
  endproperty
  a_bp32_rates: assert property (p_bp32_rates) else $error("bp rates kept");
  property p_go_pulse;
    (memTestGo & $past(memTestGo)) == 4'h0;
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("launch not a pulse");
  property p_go_enabled;
    memTestGo != 4'h0 |-> selftestEnable;
  endproperty
  a_go_enabled: assert property (p_go_enabled) else $error("launch while off");
  property p_revision;
    hostRead && hostAddr == `TSW_ADDR_REVISION |=>
      hostRdValid && hostRdData == {12'h000, REVISION_NUMBER};
  endproperty
  a_revision: assert property (p_revision) else $error("revision read");
  property p_unmapped;
    hostRead && hostAddr > 14'h014D && hostAddr < 14'h3FFF |=> hostRdData == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_local_width;
    {localSendWin.channel[8], localRecvWin.channel[8], localTxExtra[8], localRxExtra[8]}
      == 4'h0;
  endproperty
  a_local_width: assert property (p_local_width) else $error("local field width");
  c_bp32: cover property (bp32Mode [*3]);
  c_launch: cover property (memTestGo != 4'h0);
  c_rev: cover property (hostRead && hostAddr == `TSW_ADDR_REVISION);
endmodule // tsw_regs_asserts
bind tsw_regs tsw_regs_asserts #(.REVISION_NUMBER(REVISION_NUMBER)) tsw_regs_asserts_i (
  .sys_clk, .reset_n, .hostRead, .hostAddr, .hostRdData, .hostRdValid, .bp32Mode,
  .bpInRates, .bpOutRates, .bpStreamActive, .bpAdvanceHalfStep, .memTestGo,
  .selftestEnable, .localSendWin, .localRecvWin, .localTxExtra, .localRxExtra);

// [dv/tsw_regs_tb.sv]
// Self-checking testbench for the switch test and rate registers.
// Assumes design, checker and engine model compiled before it.
`include "tsw_regs_map.svh"
module tsw_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] REV = 4'h1; // Arbitrary value
  logic sys_clk = 0, reset_n = 0, hostWrite = 0, hostRead = 0, bp32Mode = 0;
  logic localBitError = 0, bpBitError = 0, hostWrReady, hostRdValid, selftestEnable;
  logic bpAdvanceHalfStep;
  logic [13:0] hostAddr = 0;
  logic [15:0] hostWrData = 0, hostRdData, rdWord;
  logic [3:0] memTestFinished, memTestPassed, memTestGo;
  tsw_pkg::tsw_window_s localSendWin, localRecvWin, bpSendWin, bpRecvWin;
  logic [8:0] localTxExtra, localRxExtra, bpTxExtra, bpRxExtra;
  logic [63:0] localInRates, localOutRates, bpInRates, bpOutRates;
  logic [31:0] bpStreamActive;
  int n_fail = 0, comparisons = 0;
  always #50 sys_clk = ~sys_clk;
  tsw_regs #(.REVISION_NUMBER(REV)) tsw_regs_i (.sys_clk, .reset_n, .hostWrite, .hostRead,
    .hostAddr, .hostWrData, .hostWrReady, .hostRdData, .hostRdValid, .bp32Mode,
    .localBitError, .bpBitError, .memTestFinished, .memTestPassed, .memTestGo,
    .selftestEnable, .localSendWin, .localTxExtra, .localRecvWin, .localRxExtra,
    .bpSendWin, .bpTxExtra, .bpRecvWin, .bpRxExtra, .localInRates, .localOutRates,
    .bpInRates, .bpOutRates, .bpStreamActive, .bpAdvanceHalfStep);
  tsw_mem_engine tsw_mem_engine_i (.sys_clk, .reset_n, .memTestGo, .memTestFinished,
    .memTestPassed);
  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Two idle edges after a write let the FIFO drain first
  task automatic wr(logic [13:0] a, logic [15:0] d);
    hostWrite = 1;
    hostAddr = a;
    hostWrData = d;
    repeat (20) if (hostWrReady !== 1'b1) @(posedge sys_clk) #1;
    @(posedge sys_clk);
    #1 hostWrite = 0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic rdchk(string what, logic [13:0] a, logic [15:0] exp);
    hostRead = 1;
    hostAddr = a;
    @(posedge sys_clk);
    #1 hostRead = 0;
    chk({what, " valid"}, hostRdValid, 1);
    chk(what, hostRdData, exp);
    // Idle edge so a following read never re-raises the strobe in this step
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_cycles(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_reset;
    rdchk("localErr", `TSW_ADDR_LOCAL_ERR, 16'h0000);
    rdchk("bpErr", `TSW_ADDR_BP_ERR, 16'h0000);
    rdchk("rate31", `TSW_ADDR_LIN_RATE + 14'd31, 16'h0000);
    rdchk("selftest", `TSW_ADDR_SELFTEST, 16'h0000);
    rdchk("revision", `TSW_ADDR_REVISION, {12'h000, REV});
    rdchk("unmapped", 14'h0200, 16'h0000);
    chk("wrReady", hostWrReady, 1);
    $display("t_reset done");
  endtask
  task automatic t_windows;
    logic [13:0] a [8] = '{`TSW_ADDR_LOCAL_SEND, `TSW_ADDR_LOCAL_TXLEN, `TSW_ADDR_LOCAL_RXLEN,
      `TSW_ADDR_LOCAL_RECV, `TSW_ADDR_BP_SEND, `TSW_ADDR_BP_TXLEN, `TSW_ADDR_BP_RXLEN,
      `TSW_ADDR_BP_RECV};
    logic [15:0] d [8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hA5C3, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'h5A5A};
    logic [15:0] e [8] = '{16'h1FFF, 16'h00FF, 16'h00FF, 16'h05C3, 16'h3FFF, 16'h01FF,
      16'h01FF, 16'h1A5A};
    for (int i = 0; i < 8; i++) begin
      wr(a[i], d[i]);
      rdchk("window", a[i], e[i]);
    end
    chk("localSendWin", localSendWin, {5'h1F, 9'h0FF});
    chk("localTxExtra", localTxExtra, 9'h0FF);
    chk("localRxExtra", localRxExtra, 9'h0FF);
    chk("localRecvWin", localRecvWin, {5'h05, 9'h0C3});
    chk("bpSendWin", bpSendWin, {5'h1F, 9'h1FF});
    chk("bpTxExtra", bpTxExtra, 9'h1FF);
    chk("bpRxExtra", bpRxExtra, 9'h1FF);
    chk("bpRecvWin", bpRecvWin, {5'h0D, 9'h05A});
    $display("t_windows done");
  endtask
  task automatic t_rates;
    logic [13:0] b [4] = '{`TSW_ADDR_LIN_RATE, `TSW_ADDR_LOUT_RATE, `TSW_ADDR_BIN_RATE,
      `TSW_ADDR_BOUT_RATE};
    for (int k = 0; k < 4; k++) begin
      wr(b[k], 16'hFFFC | 16'(k));
      wr(b[k] + 14'd31, 16'hFFFC | 16'(3 - k));
      rdchk("rate0", b[k], 16'(k));
    end
    chk("localInRates", localInRates, {2'd3, 60'h0, 2'd0});
    chk("localOutRates", localOutRates, {2'd2, 60'h0, 2'd1});
    chk("bpInRates", bpInRates, {2'd1, 60'h0, 2'd2});
    chk("bpOutRates", bpOutRates, {2'd0, 60'h0, 2'd3});
    bp32Mode = 1;
    wait_cycles(3);
    chk("bp32 rates", bpInRates | bpOutRates, 64'h0);
    chk("bp32 active", bpStreamActive, 32'h0000_FFFF);
    chk("bp32 step", bpAdvanceHalfStep, 1);
    chk("bp32 local", localInRates, {2'd3, 60'h0, 2'd0});
    bp32Mode = 0;
    wait_cycles(3);
    chk("bpOutRates back", bpOutRates, {2'd0, 60'h0, 2'd3});
    chk("normal step", bpAdvanceHalfStep, 0);
    $display("t_rates done");
  endtask
  task automatic t_errors;
    wr(`TSW_ADDR_LOCAL_ERR, 16'h1234);
    wr(`TSW_ADDR_BP_ERR, 16'h1234);
    localBitError = 1;
    wait_cycles(5);
    localBitError = 0;
    bpBitError = 1;
    wait_cycles(3);
    bpBitError = 0;
    wait_cycles(1);
    rdchk("localErr", `TSW_ADDR_LOCAL_ERR, 16'h0005);
    rdchk("bpErr", `TSW_ADDR_BP_ERR, 16'h0003);
    $display("t_errors done");
  endtask
  task automatic t_bist;
    wr(`TSW_ADDR_SELFTEST, 16'h1000);
    wr(`TSW_ADDR_SELFTEST, 16'h1800);
    rdchk("bist running", `TSW_ADDR_SELFTEST, 16'h1800);
    wait_cycles(30);
    rdchk("bist pass", `TSW_ADDR_SELFTEST, 16'h1E00);
    wr(`TSW_ADDR_SELFTEST, 16'h1000);
    wr(`TSW_ADDR_SELFTEST, 16'h1004);
    wait_cycles(30);
    rdchk("bist fail", `TSW_ADDR_SELFTEST, 16'h1606);
    chk("enable", selftestEnable, 1);
    $display("t_bist done");
  endtask
  task automatic t_midreset;
    reset_n = 0;
    wait_cycles(2);
    reset_n = 1;
    wait_cycles(2);
    rdchk("selftest rst", `TSW_ADDR_SELFTEST, 16'h0000);
    rdchk("localErr rst", `TSW_ADDR_LOCAL_ERR, 16'h0000);
    rdchk("bpSend rst", `TSW_ADDR_BP_SEND, 16'h0000);
    chk("localInRates rst", localInRates, 64'h0);
    $display("t_midreset done");
  endtask
  task automatic finish_test;
    $display("Counts: %0d compared, %0d failed", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    wait_cycles(4);
    reset_n = 1;
    wait_cycles(2);
    t_reset();
    t_windows();
    t_rates();
    t_errors();
    t_bist();
    t_midreset();
    finish_test();
  end
  initial begin
    #300_000;
    n_fail++;
    finish_test();
  end
endmodule // tsw_regs_tb

// [rtl/tsw_fifo.sv]
// Small word FIFO carrying host writes into the register bank.
// Assumes one clock; source and sink follow valid and ready.
module tsw_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } tsw_fifo_state_s;
  tsw_fifo_state_s state_reg, state_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty, push, pop;

  assign empty = state_reg.wrPtr == state_reg.rdPtr;
  assign full = (state_reg.wrPtr[AW-1:0] == state_reg.rdPtr[AW-1:0]) && !empty;
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[state_reg.rdPtr[AW-1:0]];
  assign push = inValid && !full;
  assign pop = outReady && !empty;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.wrPtr = state_reg.wrPtr + (AW+1)'(1);
    end
    if (pop) begin
      state_next.rdPtr = state_reg.rdPtr + (AW+1)'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[state_reg.wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule // tsw_fifo

// [rtl/tsw_pkg.sv]
// Types shared by the switch test and rate register block.
// Assumes the map header for numbers.
package tsw_pkg;
  typedef logic [1:0] tsw_rate_t;
  typedef struct packed {
    logic [4:0] stream;
    logic [8:0] channel;
  } tsw_window_s;
  typedef struct packed {
    logic [15:0] data;
    logic [13:0] addr;
  } tsw_word_s;
  typedef enum logic [1:0] {
    TSW_ST_IDLE,
    TSW_ST_RUN,
    TSW_ST_DONE
  } tsw_mem_state_e;
endpackage

// [rtl/tsw_regs.sv]
// Test window, rate, memory self-test and revision registers of the stream switch.
// Assumes the host port is synchronised to sys_clk; datapath supplies error and self-test events.
`include "tsw_regs_map.svh"
module tsw_regs #(
  parameter logic [3:0] REVISION_NUMBER = 4'h1, // Arbitrary value
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Host port, already in sys_clk domain
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [13:0] hostAddr,
  input wire logic [15:0] hostWrData,
  output logic hostWrReady,
  output logic [15:0] hostRdData,
  output logic hostRdValid,
  // Mode
  input wire logic bp32Mode,
  // Error events from the test receivers
  input wire logic localBitError,
  input wire logic bpBitError,
  // Memory self-test engines
  input wire logic [3:0] memTestFinished,
  input wire logic [3:0] memTestPassed,
  output logic [3:0] memTestGo,
  output logic selftestEnable,
  // Test windows
  output tsw_pkg::tsw_window_s localSendWin,
  output logic [8:0] localTxExtra,
  output tsw_pkg::tsw_window_s localRecvWin,
  output logic [8:0] localRxExtra,
  output tsw_pkg::tsw_window_s bpSendWin,
  output logic [8:0] bpTxExtra,
  output tsw_pkg::tsw_window_s bpRecvWin,
  output logic [8:0] bpRxExtra,
  // Stream rates, 32 streams of 2 bits each
  output logic [63:0] localInRates,
  output logic [63:0] localOutRates,
  output logic [63:0] bpInRates,
  output logic [63:0] bpOutRates,
  output logic [31:0] bpStreamActive,
  // Advance scale: 1 means steps of half a cycle
  output logic bpAdvanceHalfStep
);
  typedef struct packed {
    logic [15:0] localSend;
    logic [7:0] localTxLen;
    logic [7:0] localRxLen;
    logic [15:0] localRecv;
    logic [15:0] localErr;
    logic [15:0] bpSend;
    logic [8:0] bpTxLen;
    logic [8:0] bpRxLen;
    logic [15:0] bpRecv;
    logic [15:0] bpErr;
    logic [63:0] lin;
    logic [63:0] lout;
    logic [63:0] bin;
    logic [63:0] bout;
    logic stEnable;
    logic [3:0] stStart;
    logic [3:0] stDone;
    logic [3:0] stPass;
    logic [3:0] stGo;
    logic [15:0] rdData;
    logic rdValid;
    logic [63:0] bpRateOut;
    logic [63:0] bpRateIn;
    logic [31:0] active;
    logic halfStep;
  } tsw_state_s;

  tsw_state_s state_reg, state_next;
  tsw_pkg::tsw_word_s fifoIn, fifoOut;
  logic fifoValid, fifoPop;
  logic [15:0] wdata;
  logic [13:0] waddr;
  logic [15:0] rdMux;
  logic [3:0] newStart;

  assign fifoIn = '{data: hostWrData, addr: hostAddr};
  assign fifoPop = 1'b1;

  tsw_fifo #(
    .WIDTH(30),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .inValid(hostWrite),
    .inReady(hostWrReady),
    .inData(fifoIn),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoOut)
  );

  assign wdata = fifoOut.data;
  assign waddr = fifoOut.addr;
  // Start bits in ascending nibble order: local conn, bp conn, local data, bp data
  assign newStart = {wdata[`TSW_ST_BP_DATA_GO], wdata[`TSW_ST_LOC_DATA_GO],
                     wdata[`TSW_ST_BP_CONN_GO], wdata[`TSW_ST_LOC_CONN_GO]};

  // Read mux; reserved bits are zero by construction
  always_comb begin
    rdMux = 16'h0000;
    if (hostAddr >= `TSW_ADDR_LIN_RATE && hostAddr < `TSW_ADDR_LOUT_RATE) begin
      rdMux = {14'h0000, state_reg.lin[2*(hostAddr-`TSW_ADDR_LIN_RATE) +: 2]};
    end else if (hostAddr >= `TSW_ADDR_LOUT_RATE && hostAddr < `TSW_ADDR_BIN_RATE) begin
      rdMux = {14'h0000, state_reg.lout[2*(hostAddr-`TSW_ADDR_LOUT_RATE) +: 2]};
    end else if (hostAddr >= `TSW_ADDR_BIN_RATE && hostAddr < `TSW_ADDR_BOUT_RATE) begin
      rdMux = {14'h0000, state_reg.bin[2*(hostAddr-`TSW_ADDR_BIN_RATE) +: 2]};
    end else if (hostAddr >= `TSW_ADDR_BOUT_RATE && hostAddr < `TSW_ADDR_SELFTEST) begin
      rdMux = {14'h0000, state_reg.bout[2*(hostAddr-`TSW_ADDR_BOUT_RATE) +: 2]};
    end else begin
      case (hostAddr)
        `TSW_ADDR_LOCAL_SEND: rdMux = {3'h0, state_reg.localSend[12:0]};
        `TSW_ADDR_LOCAL_TXLEN: rdMux = {8'h00, state_reg.localTxLen};
        `TSW_ADDR_LOCAL_RXLEN: rdMux = {8'h00, state_reg.localRxLen};
        `TSW_ADDR_LOCAL_RECV: rdMux = {3'h0, state_reg.localRecv[12:0]};
        `TSW_ADDR_LOCAL_ERR: rdMux = state_reg.localErr;
        `TSW_ADDR_BP_SEND: rdMux = {2'h0, state_reg.bpSend[13:0]};
        `TSW_ADDR_BP_TXLEN: rdMux = {7'h00, state_reg.bpTxLen};
        `TSW_ADDR_BP_RXLEN: rdMux = {7'h00, state_reg.bpRxLen};
        `TSW_ADDR_BP_RECV: rdMux = {2'h0, state_reg.bpRecv[13:0]};
        `TSW_ADDR_BP_ERR: rdMux = state_reg.bpErr;
        `TSW_ADDR_SELFTEST: begin
          rdMux = {3'h0, state_reg.stEnable,
                   state_reg.stStart[3], state_reg.stDone[3], state_reg.stPass[3],
                   state_reg.stStart[2], state_reg.stDone[2], state_reg.stPass[2],
                   state_reg.stStart[1], state_reg.stDone[1], state_reg.stPass[1],
                   state_reg.stStart[0], state_reg.stDone[0], state_reg.stPass[0]};
        end
        `TSW_ADDR_REVISION: rdMux = {12'h000, REVISION_NUMBER};
        default: rdMux = 16'h0000;
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.rdValid = hostRead;
    state_next.rdData = hostRead ? rdMux : state_reg.rdData;
    state_next.stGo = 4'h0;
    // Saturate rather than wrap so a long run never reads as low error
    if (localBitError && state_reg.localErr != 16'hFFFF) begin
      state_next.localErr = state_reg.localErr + 16'h0001;
    end
    if (bpBitError && state_reg.bpErr != 16'hFFFF) begin
      state_next.bpErr = state_reg.bpErr + 16'h0001;
    end
    if (fifoValid) begin
      if (waddr >= `TSW_ADDR_LIN_RATE && waddr < `TSW_ADDR_LOUT_RATE) begin
        state_next.lin[2*(waddr-`TSW_ADDR_LIN_RATE) +: 2] = wdata[1:0];
      end else if (waddr >= `TSW_ADDR_LOUT_RATE && waddr < `TSW_ADDR_BIN_RATE) begin
        state_next.lout[2*(waddr-`TSW_ADDR_LOUT_RATE) +: 2] = wdata[1:0];
      end else if (waddr >= `TSW_ADDR_BIN_RATE && waddr < `TSW_ADDR_BOUT_RATE) begin
        state_next.bin[2*(waddr-`TSW_ADDR_BIN_RATE) +: 2] = wdata[1:0];
      end else if (waddr >= `TSW_ADDR_BOUT_RATE && waddr < `TSW_ADDR_SELFTEST) begin
        state_next.bout[2*(waddr-`TSW_ADDR_BOUT_RATE) +: 2] = wdata[1:0];
      end else begin
        case (waddr)
          `TSW_ADDR_LOCAL_SEND: state_next.localSend = {3'h0, wdata[12:0]};
          `TSW_ADDR_LOCAL_TXLEN: state_next.localTxLen = wdata[7:0];
          `TSW_ADDR_LOCAL_RXLEN: state_next.localRxLen = wdata[7:0];
          `TSW_ADDR_LOCAL_RECV: state_next.localRecv = {3'h0, wdata[12:0]};
          `TSW_ADDR_BP_SEND: state_next.bpSend = {2'h0, wdata[13:0]};
          `TSW_ADDR_BP_TXLEN: state_next.bpTxLen = wdata[8:0];
          `TSW_ADDR_BP_RXLEN: state_next.bpRxLen = wdata[8:0];
          `TSW_ADDR_BP_RECV: state_next.bpRecv = {2'h0, wdata[13:0]};
          `TSW_ADDR_SELFTEST: begin
            state_next.stEnable = wdata[`TSW_ST_ENABLE_BIT];
            state_next.stStart = newStart;
            for (int i = 0; i < 4; i++) begin
              // Launch only on a rising start bit with test mode held
              if (newStart[i] && !state_reg.stStart[i] && wdata[`TSW_ST_ENABLE_BIT]
                  && state_reg.stEnable) begin
                state_next.stGo[i] = 1'b1;
                state_next.stDone[i] = 1'b0;
                state_next.stPass[i] = 1'b0;
              end
            end
          end
          default: state_next.stEnable = state_reg.stEnable;
        endcase
      end
    end
    // After the write so a finish in the relaunch cycle is never lost
    for (int i = 0; i < 4; i++) begin
      if (memTestFinished[i] && state_reg.stEnable) begin
        state_next.stDone[i] = 1'b1;
        state_next.stPass[i] = memTestPassed[i];
      end
    end
    // 32M mode overrides backplane codes; upper streams idle
    for (int s = 0; s < 32; s++) begin
      state_next.active[s] = !bp32Mode || (s < 16);
    end
    state_next.bpRateIn = bp32Mode ? 64'h0 : state_next.bin;
    state_next.bpRateOut = bp32Mode ? 64'h0 : state_next.bout;
    state_next.halfStep = bp32Mode;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hostRdData = state_reg.rdData;
  assign hostRdValid = state_reg.rdValid;
  assign memTestGo = state_reg.stGo;
  assign selftestEnable = state_reg.stEnable;
  assign localSendWin = '{stream: state_reg.localSend[12:8],
                          channel: {1'b0, state_reg.localSend[7:0]}};
  assign localRecvWin = '{stream: state_reg.localRecv[12:8],
                          channel: {1'b0, state_reg.localRecv[7:0]}};
  assign bpSendWin = '{stream: state_reg.bpSend[13:9], channel: state_reg.bpSend[8:0]};
  assign bpRecvWin = '{stream: state_reg.bpRecv[13:9], channel: state_reg.bpRecv[8:0]};
  assign localTxExtra = {1'b0, state_reg.localTxLen};
  assign localRxExtra = {1'b0, state_reg.localRxLen};
  assign bpTxExtra = state_reg.bpTxLen;
  assign bpRxExtra = state_reg.bpRxLen;
  assign localInRates = state_reg.lin;
  assign localOutRates = state_reg.lout;
  assign bpInRates = state_reg.bpRateIn;
  assign bpOutRates = state_reg.bpRateOut;
  assign bpStreamActive = state_reg.active;
  assign bpAdvanceHalfStep = state_reg.halfStep;
endmodule // tsw_regs

// [rtl/tsw_regs_map.svh]
// Register offsets, field positions and reset values of the switch test and rate registers.
// Assumes a 16-bit host data path and word addresses as printed.
`ifndef TSW_REGS_MAP_SVH
`define TSW_REGS_MAP_SVH
`define TSW_ADDR_LOCAL_SEND 14'h00C3
`define TSW_ADDR_LOCAL_TXLEN 14'h00C4
`define TSW_ADDR_LOCAL_RXLEN 14'h00C5
`define TSW_ADDR_LOCAL_RECV 14'h00C6
`define TSW_ADDR_LOCAL_ERR 14'h00C7
`define TSW_ADDR_BP_SEND 14'h00C8
`define TSW_ADDR_BP_TXLEN 14'h00C9
`define TSW_ADDR_BP_RXLEN 14'h00CA
`define TSW_ADDR_BP_RECV 14'h00CB
`define TSW_ADDR_BP_ERR 14'h00CC
`define TSW_ADDR_LIN_RATE 14'h00CD
`define TSW_ADDR_LOUT_RATE 14'h00ED
`define TSW_ADDR_BIN_RATE 14'h010D
`define TSW_ADDR_BOUT_RATE 14'h012D
`define TSW_ADDR_SELFTEST 14'h014D
`define TSW_ADDR_REVISION 14'h3FFF
`define TSW_SEL_STREAM_LO_L 8
`define TSW_SEL_STREAM_LO_B 9
`define TSW_ST_ENABLE_BIT 12
`define TSW_ST_BP_DATA_GO 11
`define TSW_ST_LOC_DATA_GO 8
`define TSW_ST_BP_CONN_GO 5
`define TSW_ST_LOC_CONN_GO 2
`define TSW_RESET_WORD 16'h0000
`define TSW_RATE_RESET 2'h0
`endif
